/* design/flash_reset_sequencer.sv */
// How it works
// - Host lowers chip select only after supply setup has passed, except after a one-cycle power-good drop outside power-up.
// - Reset during power-up: honour pulse width and recovery; finish latest.
// - Reset pin high at least 50 ns before chip select falls.
// - Pulse width plus high-to-select never shorter than recovery time.
`default_nettype none
module flash_reset_sequencer
	import flash_reset_pkg::*;
#(
	parameter int unsigned SETUP_CYCLES    = SUPPLY_SETUP_CYC,
	parameter int unsigned RECOVERY_CYCLES = RECOVERY_CYC
) (
	input  wire logic CLK_SYS,
	input  wire logic RST_N,
	input  wire logic POWER_GOOD,
	input  wire logic RESET_REQ,
	input  wire logic READY_BUSY_N,
	output logic      FLASH_RESET_N,
	output logic      ACCESS_OK,
	output logic      SEQ_BUSY
);
	localparam int unsigned N_PINS = 2;

	seq_state_e   state_r;
	logic [N_PINS-1:0] pin_in;
	wire logic [N_PINS-1:0] pin_sync;
	logic         power_good;
	logic         ready_busy_n;
	logic         load;
	logic [CNT_W-1:0] count;
	logic         done;
	logic         cold_done_r;
	logic         rst_out_r;
	logic         ok_r;
	logic [CNT_W-1:0] low_cnt_r;
	logic         low_long;

	// Release is allowed only when the host has let go and the low time is complete.
	function automatic logic may_release(input logic req, input logic low_full);
		return !req && low_full;
	endfunction

	assign pin_in = {READY_BUSY_N, POWER_GOOD};

	// Pins from outside the clock domain pass two flip-flops first.
	// Only the second stage is read, so a metastable first stage never fans out.
	for (genvar i = 0; i < N_PINS; i++) begin : g_sync
		logic [1:0] stage_r;
		always_ff @(posedge CLK_SYS or negedge RST_N) begin
			if (!RST_N) begin
				stage_r <= 2'h0;
			end else begin
				stage_r <= {stage_r[0], pin_in[i]};
			end
		end
		assign pin_sync[i] = stage_r[1];
	end

	// Both synchronised pins read low after reset, which keeps the sequence in power-up.
	assign power_good   = pin_sync[0];
	assign ready_busy_n = pin_sync[1];

	// The low time is counted in cycles of the reset state, from its entry.
	assign low_long = (low_cnt_r == CNT_W'(RECOVERY_CYCLES));

	delay_counter #(.W(CNT_W)) u_delay (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.load  (load),
		.count (count),
		.done  (done)
	);

	always_comb begin
		load  = 1'b0;
		count = '0;
		case (state_r)
			ST_POWER_UP: begin
				// Supply setup restarts while power is not good.
				if (!power_good) begin
					load  = 1'b1;
					count = CNT_W'(SETUP_CYCLES);
				end
			end
			ST_RESET_LOW: begin
				if (may_release(RESET_REQ, low_long)) begin
					load  = 1'b1;
					count = CNT_W'(HIGH_SELECT_CYC);
				end
			end
			default: begin
				load  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			state_r <= ST_POWER_UP;
		end else if (!power_good) begin
			// Supply loss means the device must cold reset again.
			state_r <= ST_POWER_UP;
		end else begin
			case (state_r)
				ST_POWER_UP: begin
					// Reset pin may be low here; it is ignored by the device.
					if (done) begin
						state_r <= ST_RESET_LOW;
					end
				end
				ST_RESET_LOW: begin
					// Hold low for at least the recovery time, which covers the pulse width.
					if (may_release(RESET_REQ, low_long)) begin
						state_r <= ST_HIGH_WAIT;
					end
				end
				ST_HIGH_WAIT: begin
					if (done) begin
						state_r <= ST_RECOVER;
					end
				end
				ST_RECOVER: begin
					// Wait for busy to clear from the pin as well.
					if (ready_busy_n) begin
						state_r <= ST_READY;
					end
				end
				ST_READY: begin
					if (RESET_REQ) begin
						state_r <= ST_RESET_LOW;
					end
				end
				default: begin
					state_r <= ST_POWER_UP;
				end
			endcase
		end
	end

	// Cold load counts as done once the delay count has run out in power-up, so a one-cycle power drop outside power-up skips the setup count.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			cold_done_r <= 1'b0;
		end else if (!power_good) begin
			cold_done_r <= 1'b0;
		end else if (state_r == ST_POWER_UP && done) begin
			cold_done_r <= 1'b1;
		end
	end

	// The pin stays low from reset through the recovery count; a short request
	// is stretched rather than passed on, trading latency for a legal pulse.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			rst_out_r <= 1'b0;
		end else if (!power_good) begin
			rst_out_r <= 1'b0;
		end else if (state_r == ST_READY && RESET_REQ) begin
			rst_out_r <= 1'b0;
		end else if (state_r == ST_RESET_LOW && may_release(RESET_REQ, low_long)) begin
			rst_out_r <= 1'b1;
		end
	end

	// Low time before release is the recovery time, so low plus high exceeds it.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			low_cnt_r <= '0;
		end else if (state_r != ST_RESET_LOW) begin
			low_cnt_r <= '0;
		end else if (low_cnt_r != CNT_W'(RECOVERY_CYCLES)) begin
			low_cnt_r <= low_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ok_r <= 1'b0;
		end else begin
			ok_r <= (state_r == ST_READY) && power_good && cold_done_r && !RESET_REQ;
		end
	end

	// The reset pin release waits for the recovery count as well as the request.
	assign FLASH_RESET_N = rst_out_r;
	assign ACCESS_OK     = ok_r;
	assign SEQ_BUSY      = (state_r != ST_READY);
endmodule
`default_nettype wire

/* shared/flash_reset_pkg.sv */
`default_nettype none
package flash_reset_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	// Times in their printed units.
	localparam int unsigned CORE_SUPPLY_SETUP_US = 300;
	localparam int unsigned IO_SUPPLY_SETUP_US   = 300;
	localparam int unsigned RESET_RECOVERY_US    = 35;
	localparam int unsigned RESET_PULSE_MIN_NS   = 200;
	localparam int unsigned RESET_HIGH_SELECT_NS = 50;
	// Least times round up to whole cycles.
	localparam int unsigned SUPPLY_SETUP_US = (CORE_SUPPLY_SETUP_US > IO_SUPPLY_SETUP_US) ?
		CORE_SUPPLY_SETUP_US : IO_SUPPLY_SETUP_US;
	localparam int unsigned SUPPLY_SETUP_CYC = (SUPPLY_SETUP_US * (CLK_HZ / 1_000_000));
	localparam int unsigned RECOVERY_CYC     = (RESET_RECOVERY_US * (CLK_HZ / 1_000_000));
	localparam int unsigned PULSE_CYC        =
		(RESET_PULSE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned HIGH_SELECT_CYC  =
		(RESET_HIGH_SELECT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned CNT_W = 24;
	typedef enum logic [2:0] {
		ST_POWER_UP   = 3'b000,
		ST_RESET_LOW  = 3'b001,
		ST_RECOVER    = 3'b010,
		ST_HIGH_WAIT  = 3'b011,
		ST_READY      = 3'b100
	} seq_state_e;
endpackage
`default_nettype wire

/* design/delay_counter.sv */
`default_nettype none
module delay_counter
	import flash_reset_pkg::*;
#(
	parameter int unsigned W = CNT_W
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              done
);
	logic [W-1:0] cnt_r;

	// Done is high once the loaded count has run down to zero.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (load) begin
			cnt_r <= count;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	assign done = (cnt_r == '0) && !load;
endmodule
`default_nettype wire

/* verification/flash_reset_sequencer_props.sv */
`default_nettype none
module flash_reset_sequencer_props (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic POWER_GOOD,
	input wire logic RESET_REQ,
	input wire logic READY_BUSY_N,
	input wire logic FLASH_RESET_N,
	input wire logic ACCESS_OK,
	input wire logic SEQ_BUSY
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	sequence pin_low;
		!FLASH_RESET_N [*8];
	endsequence
	sequence gone_busy;
		!FLASH_RESET_N ##1 !ACCESS_OK;
	endsequence
	a_pulse_width: assert property ($fell(FLASH_RESET_N) |-> pin_low)
		else $error("reset pulse short");
	a_high_first: assert property ($rose(ACCESS_OK) |-> FLASH_RESET_N && $past(FLASH_RESET_N))
		else $error("select too soon after reset");
	a_ready_first: assert property ($rose(ACCESS_OK) |-> $past(READY_BUSY_N) && POWER_GOOD)
		else $error("select while flash busy");
	a_request_taken: assert property (RESET_REQ && !SEQ_BUSY |=> gone_busy)
		else $error("reset request not answered");
endmodule
bind flash_reset_sequencer flash_reset_sequencer_props props (.*);
`default_nettype wire

/* verification/flash_model.sv */
`default_nettype none
module flash_model #(
	parameter int S = 60,
	parameter int R = 30
) (
	input  wire logic clk,
	input  wire logic pwr,
	input  wire logic pin_n,
	output logic      rdy_n
);
	timeunit 1ns;
	timeprecision 100ps;
	int   n = 0;
	logic cold = 1'b1;
	logic p = 1'b1;
	// The pin is only looked at once the cold load has run its full length.
	always @(posedge clk) begin
		p <= pin_n;
		if (!pwr) begin
			n <= S;
			cold <= 1'b1;
		end else if (n > 0) n <= n - 1;
		else if (cold) begin
			cold <= 1'b0;
			if (!pin_n) n <= R;
		end else if (p && !pin_n) n <= R;
	end
	assign rdy_n = (n == 0) && !cold;
endmodule
`default_nettype wire

/* verification/flash_reset_sequencer_test.sv */
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("Error %s expected %0h seen %0h", n, e, g); end end
module flash_reset_sequencer_test import flash_reset_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;
	localparam int SU = 50;
	localparam int RC = 20;
	logic CLK_SYS = 0, RST_N = 0, POWER_GOOD = 0, RESET_REQ = 0, ao_q = 0;
	wire logic READY_BUSY_N, FLASH_RESET_N, ACCESS_OK, SEQ_BUSY;
	int num_errors = 0, checks = 0, seed = 32'h6e6e2e93, pg = 0, sf = 0, hi = 0, n;
	always #12.5 CLK_SYS = ~CLK_SYS;
	flash_reset_sequencer #(.SETUP_CYCLES(SU), .RECOVERY_CYCLES(RC)) dut (.*);
	flash_model #(.S(SU + 10), .R(RC + 10)) far (.clk(CLK_SYS), .pwr(POWER_GOOD),
		.pin_n(FLASH_RESET_N), .rdy_n(READY_BUSY_N));
	function automatic bit may_select(int p, int s, int h);
		return p >= SU && s >= RC && h >= HIGH_SELECT_CYC;
	endfunction
	always @(posedge CLK_SYS) begin
		pg <= POWER_GOOD ? pg + 1 : 0;
		sf <= (!RST_N || (hi > 0 && !FLASH_RESET_N)) ? 0 : sf + 1;
		hi <= FLASH_RESET_N ? hi + 1 : 0;
		ao_q <= ACCESS_OK;
		if (ACCESS_OK && !ao_q)
			`CHK("select gap", 1'b1, may_select(pg, sf, hi))
	end
	task automatic wait_ok(int t);
		n = 0;
		// One edge lets a just-taken request pull the old ready level down first.
		@(posedge CLK_SYS);
		while (ACCESS_OK !== 1'b1 && n < 2000) begin
			@(posedge CLK_SYS);
			n++;
		end
		`CHK("access", 1'b1, ACCESS_OK)
		$display("test %0d done", t);
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#(25 * 30000);
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (5) @(posedge CLK_SYS);
		RST_N <= 1;
		POWER_GOOD <= 1;
		wait_ok(0);
		for (int t = 1; t < 9; t++) begin
			repeat ($unsigned($random(seed)) % 20) @(posedge CLK_SYS);
			RESET_REQ <= 1;
			if (t == 5) begin
				@(posedge CLK_SYS);
				POWER_GOOD <= 0;
				@(posedge CLK_SYS);
				POWER_GOOD <= 1;
			end
			repeat (t == 1 ? 1 : $unsigned($random(seed)) % 80 + 1) @(posedge CLK_SYS);
			RESET_REQ <= 0;
			wait_ok(t);
		end
		end_sim();
	end
endmodule
`default_nettype wire
